//--- verilog/pmeac_pkg.sv
// Shared constants and types for the power mode exit and strobe control block
package pmeac_pkg;
  // ****************
  // Register map
  // ****************
  localparam int ADDR_W = 8;
  localparam logic [7:0] PWR_CTL_OFF = 8'h00;
  localparam logic [7:0] AUX_CTL_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] CONFIG_OFF = 8'h0c;
  localparam logic [7:0] PORT_ZERO_OFF = 8'h10;
  localparam logic [7:0] PORT_HIGH_OFF = 8'h14;
  localparam logic [7:0] RAM_BASE = 8'h40;
  localparam logic [7:0] RAM_MASK = 8'hc0;
  // ****************
  // Fields and reset values
  // ****************
  localparam int IDLE_BIT = 0;
  localparam int PDOWN_BIT = 1;
  localparam int GF0_BIT = 2;
  localparam int GF1_BIT = 3;
  localparam int STROBE_OFF_BIT = 0;
  localparam int EXT_CODE_BIT = 0;
  localparam int OSC_RUN_BIT = 4;
  localparam logic [3:0] PWR_CTL_RST = 4'h0;
  localparam logic AUX_CTL_RST = 1'b0;
  localparam logic CONFIG_RST = 1'b0;
  localparam logic [7:0] PORT_RST = 8'hff;
  // ****************
  // Timing and sizes
  // ****************
  localparam int WAKE_CLKS = 1024;
  localparam int RAM_WORDS = 16;
  localparam int RAM_AW = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    S_RUN = 4'h1,
    S_IDLE = 4'h2,
    S_PD = 4'h4,
    S_WAKE = 4'h8
  } pmeac_state_t;
endpackage : pmeac_pkg

//--- verilog/pmeac_ram.sv
// Internal data RAM with registered read port and no reset
`timescale 1ns/10ps
module pmeac_ram #(
  parameter int DW = 8,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Contents never see reset, so they survive every wake path
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : pmeac_ram

//--- verilog/pmeac_top.sv
// Power mode sequencing, port state and address strobe control
`timescale 1ns/10ps
module pmeac_top
  import pmeac_pkg::*;
#(
  parameter int WAKE_CYCLES = pmeac_pkg::WAKE_CLKS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmeac_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmeac_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq_any,
  input wire logic ext_wake_irq,
  input wire logic kbd_wake_irq,
  input wire logic external_data_move_instr,
  input wire logic code_table_read_instr,
  input wire logic ext_fetch,
  input wire logic core_addr_latch,
  input wire logic core_prog_strobe,
  input wire logic [7:0] core_port_zero_out,
  input wire logic [7:0] core_port_zero_oe,
  input wire logic [7:0] core_addr_high,
  output logic addr_latch_strobe,
  output logic addr_latch_strobe_oe,
  output logic program_store_strobe,
  output logic [7:0] bus_port_zero_out,
  output logic [7:0] bus_port_zero_oe,
  output logic [7:0] high_address_port_out,
  output logic osc_run
);
  import pmeac_pkg::*;

  // ****************
  // Decode helpers
  // ****************
  function automatic logic is_ram(input logic [ADDR_W-1:0] a);
    return (a & RAM_MASK) == RAM_BASE && a[1:0] == 2'h0;
  endfunction : is_ram

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return is_ram(a) || a == PWR_CTL_OFF || a == AUX_CTL_OFF || a == STATUS_OFF
      || a == CONFIG_OFF || a == PORT_ZERO_OFF || a == PORT_HIGH_OFF;
  endfunction : is_mapped

  localparam int CNT_W = $clog2(WAKE_CYCLES);

  // ****************
  // Registers and state
  // ****************
  pmeac_state_t st;
  pmeac_state_t next_st;
  logic [3:0] power_control_register;
  logic auxiliary_control_register;
  logic ext_code;
  logic [7:0] port_zero_latch;
  logic [7:0] port_high_latch;
  logic [CNT_W-1:0] wake_cnt;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic [ADDR_W-1:0] ar_addr;
  logic rd_wait;
  logic [7:0] ram_rdata;

  // ****************
  // Bus decode
  // ****************
  wire do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_lane = do_wr && w_strb[0];
  wire wr_pwr = wr_lane && aw_addr == PWR_CTL_OFF;
  wire wr_aux = wr_lane && aw_addr == AUX_CTL_OFF;
  wire wr_cfg = wr_lane && aw_addr == CONFIG_OFF;
  wire wr_pz = wr_lane && aw_addr == PORT_ZERO_OFF;
  wire wr_ph = wr_lane && aw_addr == PORT_HIGH_OFF;
  wire wr_ram = wr_lane && is_ram(aw_addr);
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire strobe_off_bit = auxiliary_control_register;
  wire idle_request_bit = power_control_register[IDLE_BIT];
  wire powerdown_request_bit = power_control_register[PDOWN_BIT];

  // ****************
  // Mode sequencing
  // ****************
  wire wake_done = wake_cnt == CNT_W'(WAKE_CYCLES - 1);
  wire idle_exit = st == S_IDLE && irq_any;
  wire pd_ext_exit = st == S_PD && ext_wake_irq;
  wire pd_kbd_exit = st == S_PD && !ext_wake_irq && kbd_wake_irq;
  wire wake_exit = st == S_WAKE && wake_done;
  wire clr_both = pd_ext_exit || wake_exit;
  wire clr_idle = idle_exit || clr_both;

  always_comb begin
    next_st = st;
    case (st)
      S_RUN: begin
        if (powerdown_request_bit) begin
          next_st = S_PD;
        end else if (idle_request_bit) begin
          next_st = S_IDLE;
        end
      end
      S_IDLE: begin
        if (idle_exit) begin
          next_st = S_RUN;
        end
      end
      S_PD: begin
        if (pd_ext_exit) begin
          next_st = S_RUN;
        end else if (pd_kbd_exit) begin
          next_st = S_WAKE;
        end
      end
      S_WAKE: begin
        if (wake_done) begin
          next_st = S_RUN;
        end
      end
      default: begin
        next_st = S_RUN;
      end
    endcase
  end

  // Software write wins over a hardware clear in the same cycle
  wire [3:0] next_pwr_ctl = wr_pwr ? w_data[3:0]
    : {power_control_register[3:2], power_control_register[PDOWN_BIT] & ~clr_both,
       power_control_register[IDLE_BIT] & ~clr_idle};

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= S_RUN;
      power_control_register <= PWR_CTL_RST;
      auxiliary_control_register <= AUX_CTL_RST;
      ext_code <= CONFIG_RST;
      port_zero_latch <= PORT_RST;
      port_high_latch <= PORT_RST;
      wake_cnt <= '0;
    end else begin
      st <= next_st;
      power_control_register <= next_pwr_ctl;
      if (wr_aux) begin
        auxiliary_control_register <= w_data[STROBE_OFF_BIT];
      end
      if (wr_cfg) begin
        ext_code <= w_data[EXT_CODE_BIT];
      end
      if (wr_pz) begin
        port_zero_latch <= w_data[7:0];
      end
      if (wr_ph) begin
        port_high_latch <= w_data[7:0];
      end
      wake_cnt <= st == S_WAKE ? wake_cnt + 1'b1 : '0;
    end
  end

  // ****************
  // Pin state
  // ****************
  wire in_idle = st == S_IDLE;
  wire in_pd = st == S_PD || st == S_WAKE;
  wire low_pwr = in_idle || in_pd;
  wire strobe_need = external_data_move_instr || code_table_read_instr || ext_fetch;
  wire strobe_quiet = strobe_off_bit && !strobe_need;
  wire next_ale = in_idle ? 1'b1 : in_pd ? 1'b0 : strobe_quiet ? 1'b1 : core_addr_latch;
  wire next_ale_oe = low_pwr || !strobe_quiet;
  wire next_program_store_strobe = in_idle ? 1'b1 : in_pd ? 1'b0 : core_prog_strobe;
  wire [7:0] next_pz_out = low_pwr ? port_zero_latch : core_port_zero_out;
  wire [7:0] next_pz_oe = !low_pwr ? core_port_zero_oe
    : ext_code ? 8'h00 : ~port_zero_latch;
  wire [7:0] next_ph_out = ext_code && !in_pd ? core_addr_high : port_high_latch;

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_latch_strobe <= 1'b1;
      addr_latch_strobe_oe <= 1'b1;
      program_store_strobe <= 1'b1;
      bus_port_zero_out <= PORT_RST;
      bus_port_zero_oe <= 8'h00;
      high_address_port_out <= PORT_RST;
      osc_run <= 1'b1;
    end else begin
      addr_latch_strobe <= next_ale;
      addr_latch_strobe_oe <= next_ale_oe;
      program_store_strobe <= next_program_store_strobe;
      bus_port_zero_out <= next_pz_out;
      bus_port_zero_oe <= next_pz_oe;
      high_address_port_out <= next_ph_out;
      osc_run <= next_st != S_PD;
    end
  end

  // ****************
  // Bus slave
  // ****************
  pmeac_ram #(
    .DW(8),
    .AW(RAM_AW)
  ) u_ram (
    .clk(clk),
    .we(wr_ram),
    .waddr(aw_addr[RAM_AW+1:2]),
    .wdata(w_data[7:0]),
    .raddr(s_axi_araddr[RAM_AW+1:2]),
    .rdata(ram_rdata)
  );

  wire [7:0] rd_byte = is_ram(ar_addr) ? ram_rdata
    : ar_addr == PWR_CTL_OFF ? {4'h0, power_control_register}
    : ar_addr == AUX_CTL_OFF ? {7'h00, auxiliary_control_register}
    : ar_addr == STATUS_OFF ? {3'h0, osc_run, st}
    : ar_addr == CONFIG_OFF ? {7'h00, ext_code}
    : ar_addr == PORT_ZERO_OFF ? port_zero_latch
    : ar_addr == PORT_HIGH_OFF ? port_high_latch : 8'h00;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      rd_wait <= 1'b0;
      aw_addr <= '0;
      ar_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      rd_wait <= ar_fire;
      if (ar_fire) begin
        s_axi_arready <= 1'b0;
        ar_addr <= s_axi_araddr;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_wait) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= is_mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_reset_regs;
    disable iff (1'b0) rst |=> power_control_register == PWR_CTL_RST && !auxiliary_control_register;
  endproperty
  a_reset_regs: assert property (p_reset_regs) else $error("regs not at reset value");

  property p_ext_keep;
    pd_ext_exit && !do_wr |=> auxiliary_control_register == $past(auxiliary_control_register)
      && ext_code == $past(ext_code);
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("regs changed by wake");

  property p_both_clear;
    st == S_PD && ext_wake_irq && idle_request_bit && !wr_pwr |=> !idle_request_bit
      && !powerdown_request_bit && st == S_RUN ##1 st == S_RUN;
  endproperty
  a_both_clear: assert property (p_both_clear) else $error("idle entered after wake");

  property p_idle_pins;
    in_idle |=> addr_latch_strobe && program_store_strobe && addr_latch_strobe_oe;
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("strobes not high in idle");

  property p_pd_pins;
    in_pd |=> !addr_latch_strobe && !program_store_strobe;
  endproperty
  a_pd_pins: assert property (p_pd_pins) else $error("strobes not low in power-down");

  property p_float;
    low_pwr && ext_code |=> bus_port_zero_oe == 8'h00;
  endproperty
  a_float: assert property (p_float) else $error("port zero driven with external code");

  property p_zero_only;
    low_pwr |=> (bus_port_zero_oe & bus_port_zero_out) == 8'h00;
  endproperty
  a_zero_only: assert property (p_zero_only) else $error("port zero drives a one");

  property p_strobe_run;
    st == S_RUN && !strobe_off_bit |=> addr_latch_strobe_oe && addr_latch_strobe == $past(core_addr_latch);
  endproperty
  a_strobe_run: assert property (p_strobe_run) else $error("strobe not following core");

  property p_strobe_quiet;
    st == S_RUN && strobe_quiet |=> !addr_latch_strobe_oe && addr_latch_strobe;
  endproperty
  a_strobe_quiet: assert property (p_strobe_quiet) else $error("strobe not released");

  property p_strobe_need;
    st == S_RUN && strobe_need |=> addr_latch_strobe_oe && addr_latch_strobe == $past(core_addr_latch);
  endproperty
  a_strobe_need: assert property (p_strobe_need) else $error("needed strobe missing");

  property p_idle_exit;
    idle_exit && !wr_pwr |=> st == S_RUN && !idle_request_bit;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle not ended");

  property p_pd_stay;
    st == S_PD && !ext_wake_irq && !kbd_wake_irq |=> st == S_PD && !osc_run;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without cause");

  property p_wake_len;
    pd_kbd_exit |=> st == S_WAKE && wake_cnt == '0;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake count not started");

  property p_wake_end;
    st == S_WAKE && wake_cnt == CNT_W'(WAKE_CYCLES - 2) |=> st == S_WAKE ##1 st == S_RUN;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake length wrong");
endmodule : pmeac_top

//--- test/pmeac_ext_mem.sv
// External memory model on the multiplexed bus
`timescale 1ns/10ps
module pmeac_ext_mem (
  input wire logic clk,
  input wire logic ale_pin,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p2_out,
  output int pulses,
  output logic [15:0] last_addr
);
  int n_pulse = 0;
  logic [15:0] addr_q = 16'h0000;
  logic ale_q = 1'b1;
  assign pulses = n_pulse;
  assign last_addr = addr_q;
  // Address is latched on each falling strobe seen at the pin
  always @(posedge clk) begin
    ale_q <= ale_pin;
    if (ale_q && !ale_pin) begin
      n_pulse <= n_pulse + 1;
      addr_q <= {p2_out, p0_out};
    end
  end
endmodule : pmeac_ext_mem

//--- test/tb.sv
// Self-checking bench for the power mode and strobe block
`timescale 1ns/10ps
module tb;
  import pmeac_pkg::*;
  localparam int WK = 8;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_run, ale_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr, core_port_zero_out, core_port_zero_oe, core_addr_high;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic irq_any, ext_wake_irq, kbd_wake_irq, external_data_move_instr, code_table_read_instr, ext_fetch;
  logic core_addr_latch, core_prog_strobe, addr_latch_strobe, addr_latch_strobe_oe, program_store_strobe;
  logic [7:0] bus_port_zero_out, bus_port_zero_oe, high_address_port_out;
  logic [15:0] last_addr;
  int pulses, errors, n_compared, cyc, n, pw, ax, cf, p0, p2, st;
  int ram [16];
  pmeac_top #(.WAKE_CYCLES(WK)) i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_any, .ext_wake_irq, .kbd_wake_irq, .external_data_move_instr,
    .code_table_read_instr, .ext_fetch, .core_addr_latch, .core_prog_strobe, .core_port_zero_out,
    .core_port_zero_oe, .core_addr_high, .addr_latch_strobe, .addr_latch_strobe_oe,
    .program_store_strobe, .bus_port_zero_out, .bus_port_zero_oe, .high_address_port_out, .osc_run);
  assign ale_pin = addr_latch_strobe_oe ? addr_latch_strobe : 1'b1;
  pmeac_ext_mem i_mem (.clk(clk), .ale_pin(ale_pin), .p0_out(bus_port_zero_out),
    .p2_out(high_address_port_out), .pulses(pulses), .last_addr(last_addr));
  // ****************
  // Model and tasks
  // ****************
  function automatic logic [1:0] mwr(input logic [7:0] a, input int d);
    case (a)
      PWR_CTL_OFF: pw = d & 15;
      AUX_CTL_OFF: ax = d & 1;
      STATUS_OFF: ;
      CONFIG_OFF: cf = d & 1;
      PORT_ZERO_OFF: p0 = d & 255;
      PORT_HIGH_OFF: p2 = d & 255;
      default: if ((a & RAM_MASK) == RAM_BASE) ram[a[5:2]] = d & 255; else return RESP_SLVERR;
    endcase
    return RESP_OKAY;
  endfunction : mwr
  function automatic logic [33:0] mexp(input logic [7:0] a);
    case (a)
      PWR_CTL_OFF: return {RESP_OKAY, 32'(pw)};
      AUX_CTL_OFF: return {RESP_OKAY, 32'(ax)};
      STATUS_OFF: return {RESP_OKAY, 32'(st | (st == 4 ? 0 : 16))};
      CONFIG_OFF: return {RESP_OKAY, 32'(cf)};
      PORT_ZERO_OFF: return {RESP_OKAY, 32'(p0)};
      PORT_HIGH_OFF: return {RESP_OKAY, 32'(p2)};
      default: if ((a & RAM_MASK) == RAM_BASE) return {RESP_OKAY, 32'(ram[a[5:2]])};
    endcase
    return {RESP_SLVERR, 32'h0};
  endfunction : mexp
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input int d);
    logic ad, wd;
    logic [1:0] e;
    ad = 0;
    wd = 0;
    e = mwr(a, d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awready && !ad) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, e);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk({s_axi_rresp, s_axi_rdata}, mexp(a));
  endtask : rd
  task automatic rd_all;
    for (int i = 0; i < 22; i++) rd(8'(i < 6 ? 4 * i : 40 + 4 * i));
  endtask : rd_all
  task automatic tog(input int k);
    repeat (k) begin
      core_addr_latch <= 1'b0;
      tick(2);
      core_addr_latch <= 1'b1;
      tick(2);
    end
    tick(2);
  endtask : tog
  task automatic pins(input logic [2:0] e);
    tick(3);
    chk({addr_latch_strobe, addr_latch_strobe_oe, program_store_strobe}, e);
  endtask : pins
  task automatic test_done;
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    void'($urandom(32'h8fcd68e6));
    {rst, core_addr_latch, core_prog_strobe} = 3'b111;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {irq_any, ext_wake_irq, kbd_wake_irq, external_data_move_instr, code_table_read_instr, ext_fetch} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hf;
    core_port_zero_out = 8'($urandom);
    core_port_zero_oe = 8'($urandom);
    core_addr_high = 8'($urandom);
    {pw, ax, cf, p0, p2, st} = {32'd0, 32'd0, 32'd0, 32'd255, 32'd255, 32'd1};
    tick(4);
    rst <= 1'b0;
    for (int i = 0; i < 16; i++) wr(8'(64 + 4 * i), $urandom);
    wr(8'h30, $urandom);
    rd(8'h20);
    rd_all();
    $display("test reset and map done");
    wr(PORT_ZERO_OFF, $urandom);
    wr(PORT_HIGH_OFF, $urandom);
    wr(STATUS_OFF, 32'h3);
    wr(PWR_CTL_OFF, 32'hc);
    n = pulses;
    tog(3);
    chk(pulses - n, 3);
    wr(AUX_CTL_OFF, 32'h1);
    n = pulses;
    tog(3);
    chk(pulses - n, 0);
    pins(3'b101);
    for (int k = 0; k < 3; k++) begin
      {external_data_move_instr, code_table_read_instr, ext_fetch} <= 3'b001 << k;
      tick(2);
      n = pulses;
      tog(2);
      chk(pulses - n, 2);
    end
    {external_data_move_instr, code_table_read_instr, ext_fetch} <= 3'b000;
    chk(last_addr, {8'(p2), core_port_zero_out});
    rd_all();
    $display("test strobe control done");
    core_addr_latch <= 1'b0;
    core_prog_strobe <= 1'b0;
    for (int x = 0; x < 2; x++) begin
      wr(CONFIG_OFF, x);
      wr(PWR_CTL_OFF, pw | 1);
      st = 2;
      pins(3'b111);
      if (x == 0) chk({bus_port_zero_out, bus_port_zero_oe, high_address_port_out}, {8'(p0), ~8'(p0), 8'(p2)});
      else chk({bus_port_zero_oe, high_address_port_out}, {8'h00, core_addr_high});
      rd(STATUS_OFF);
      irq_any <= 1'b1;
      tick(2);
      irq_any <= 1'b0;
      pw = pw & 14;
      st = 1;
      rd(PWR_CTL_OFF);
    end
    $display("test idle done");
    core_addr_latch <= 1'b1;
    core_prog_strobe <= 1'b1;
    wr(PWR_CTL_OFF, pw | 3);
    st = 4;
    pins(3'b010);
    chk({osc_run, bus_port_zero_oe, high_address_port_out}, {1'b0, 8'h00, 8'(p2)});
    irq_any <= 1'b1;
    tick(5);
    rd(STATUS_OFF);
    irq_any <= 1'b0;
    ext_wake_irq <= 1'b1;
    tick(1);
    ext_wake_irq <= 1'b0;
    pw = pw & 12;
    st = 1;
    pins(3'b101);
    rd_all();
    $display("test external wake done");
    wr(CONFIG_OFF, 0);
    wr(PWR_CTL_OFF, pw | 2);
    st = 4;
    tick(3);
    kbd_wake_irq <= 1'b1;
    tick(1);
    kbd_wake_irq <= 1'b0;
    tick(2);
    chk({addr_latch_strobe, program_store_strobe, osc_run}, 3'b001);
    tick(4);
    chk({addr_latch_strobe, program_store_strobe}, 2'b00);
    tick(5);
    chk({addr_latch_strobe, program_store_strobe}, 2'b11);
    pw = pw & 12;
    st = 1;
    rd(PWR_CTL_OFF);
    $display("test keyboard wake done");
    wr(AUX_CTL_OFF, 32'h1);
    wr(PWR_CTL_OFF, pw | 2);
    tick(3);
    rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    {pw, ax, cf, p0, p2, st} = {32'd0, 32'd0, 32'd0, 32'd255, 32'd255, 32'd1};
    rd_all();
    $display("test reset exit done");
    test_done();
  end
endmodule : tb
